// ===== daa_pkg.sv
// package: constants and types for data address arithmetic
// Overview of operation
// - Short indexed mode adds a 7-bit signed displacement (-64..+63) to the base and accesses in one cycle.
// - Long indexed mode adds a 16-bit signed displacement from the second word and accesses in two cycles.
// - The indexed address is formed before the access and the base pointer is left unchanged.
// - Indexed add, subtract, compare, and, or, xor and moves take one cycle short and two cycles long.
// - The base pointer is a general register that can be written, read and loaded from the stack pointer.
// - A dedicated 16-bit stack pointer always holds the address of the last pushed entry.
// - The stack grows toward lower addresses.
// - Push decrements then writes; pop reads at the pointer then increments.
// - Calls and interrupts push the program counter and returns pop it back.
// - Modulo stepping with a negative step loads the modulo value when the low k bits are zero.
package daa_pkg;

	localparam int        DATA_W        = 16;
	localparam int        DISP_SHORT_W  = 7;
	localparam logic [15:0] BASE_RESET  = 16'h0000;
	localparam logic [15:0] STACK_RESET = 16'h0000;
	localparam logic [15:0] ONE         = 16'h0001;

	// ---------------------------------------------------------------
	// command set
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_NONE       = 4'h0,
		OP_IDX_SHORT  = 4'h1,
		OP_IDX_LONG   = 4'h2,
		OP_PUSH       = 4'h3,
		OP_POP        = 4'h4,
		OP_CALL       = 4'h5,
		OP_INTR       = 4'h6,
		OP_RET        = 4'h7,
		OP_WR_BASE    = 4'h8,
		OP_BASE_FROM_SP = 4'h9,
		OP_WR_STACK   = 4'hA,
		OP_MOD_STEP   = 4'hB
	} op_t;

	typedef enum logic [2:0] {
		ALU_ADD   = 3'h0,
		ALU_SUB   = 3'h1,
		ALU_CMP   = 3'h2,
		ALU_AND   = 3'h3,
		ALU_OR    = 3'h4,
		ALU_XOR   = 3'h5,
		ALU_LOAD  = 3'h6,
		ALU_STORE = 3'h7
	} alu_t;

	// gray steps: idle -> long -> idle and idle -> pop wait -> idle
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_LONG = 2'h1,
		ST_POPW = 2'h2
	} state_t;

	typedef struct packed {
		logic        valid;
		op_t         op;
		alu_t        alu;
		logic [6:0]  disp7;
		logic [15:0] value;
	} cmd_t;

	typedef struct packed {
		logic [15:0] ptr;
		logic [15:0] step;
		logic [15:0] modsz;
	} mod_req_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
		logic        idx;
		alu_t        alu;
	} mem_t;

endpackage : daa_pkg

// ===== modulo_step.sv
// module: modulo post-modification of an address pointer
`timescale 1ns/1ns
module modulo_step (
	// request
	input  wire daa_pkg::mod_req_t req_i,
	// result
	output logic [15:0]            ptr_o
);

	// --------------------------------------------------------------
	// window mask: smallest all-ones field covering the modulo value
	// --------------------------------------------------------------
	function automatic logic [15:0] window_mask(input logic [15:0] m);
		logic [15:0] r;
		r = m;
		r = r | (r >> 1);
		r = r | (r >> 2);
		r = r | (r >> 4);
		r = r | (r >> 8);
		return r;
	endfunction : window_mask

	logic [15:0] mask;
	logic [15:0] low;
	logic [15:0] sum;

	always_comb begin
		mask  = window_mask(req_i.modsz);
		low   = req_i.ptr & mask;
		sum   = req_i.ptr + req_i.step;
		ptr_o = req_i.ptr;
		if (req_i.modsz != 16'h0000) begin
			if (!req_i.step[15] && low == req_i.modsz) begin
				ptr_o = req_i.ptr & ~mask;
			end else if (req_i.step[15] && low == 16'h0000) begin
				ptr_o = (req_i.ptr & ~mask) | req_i.modsz;
			end else begin
				ptr_o = (req_i.ptr & ~mask) | (sum & mask);
			end
		end
	end

endmodule : modulo_step

// ===== data_address_arithmetic.sv
// module: indexed addressing, stack pointer and program counter save/restore
`timescale 1ns/1ns
module data_address_arithmetic (
	// clock and reset
	input  wire logic              clk_sys_i,
	input  wire logic              rst_i,
	// decoder command
	input  wire daa_pkg::cmd_t     cmd_i,
	input  wire logic [15:0]       ext_word_i,
	input  wire daa_pkg::mod_req_t mod_i,
	// data memory
	input  wire logic [15:0]       mem_rdata_i,
	output daa_pkg::mem_t          mem_o,
	// core side results
	output logic                   busy_o,
	output logic [15:0]            index_base_pointer_o,
	output logic [15:0]            stack_top_pointer_o,
	output logic [15:0]            program_counter_o,
	output logic                   program_counter_load_o,
	output logic [15:0]            pop_data_o,
	output logic                   pop_valid_o,
	output logic [15:0]            address_pointer_o,
	output logic                   address_pointer_valid_o
);

	typedef struct packed {
		// sequencing
		daa_pkg::state_t state;
		logic            busy;
		daa_pkg::alu_t   pend_alu;
		logic [15:0]     pend_value;
		logic            pend_pc;
		// pointers
		logic [15:0]     base;
		logic [15:0]     sp;
		logic [15:0]     ptr;
		logic            ptr_valid;
		// memory request
		daa_pkg::mem_t   mem;
		// results
		logic [15:0]     pc;
		logic            pc_load;
		logic [15:0]     pop_data;
		logic            pop_valid;
	} regs_t;

	regs_t       s_q;
	regs_t       s_d;
	logic [15:0] mod_ptr;

	// --------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------
	function automatic logic [15:0] sext7(input logic [6:0] d);
		return {{9{d[6]}}, d};
	endfunction : sext7

	function automatic logic [15:0] add16(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] t;
		t = {1'b0, a} + {1'b0, b};
		return t[15:0];
	endfunction : add16

	// stack pointer one step down and up, wrapping at 16 bits
	function automatic logic [15:0] dec16(input logic [15:0] a);
		return a - daa_pkg::ONE;
	endfunction : dec16

	function automatic logic [15:0] inc16(input logic [15:0] a);
		return a + daa_pkg::ONE;
	endfunction : inc16

	function automatic daa_pkg::mem_t idx_access(input logic [15:0] ea,
			input daa_pkg::alu_t alu, input logic [15:0] value);
		daa_pkg::mem_t m;
		m.addr  = ea;
		m.wdata = value;
		m.wr    = (alu == daa_pkg::ALU_STORE);
		m.rd    = (alu != daa_pkg::ALU_STORE);
		m.idx   = 1'b1;
		m.alu   = alu;
		return m;
	endfunction : idx_access

	function automatic daa_pkg::mem_t stack_access(input logic [15:0] a,
			input logic [15:0] value, input logic wr);
		daa_pkg::mem_t m;
		m.addr  = a;
		m.wdata = value;
		m.wr    = wr;
		m.rd    = !wr;
		m.idx   = 1'b0;
		m.alu   = daa_pkg::ALU_LOAD;
		return m;
	endfunction : stack_access

	modulo_step u_modulo (
		.req_i (mod_i),
		.ptr_o (mod_ptr)
	);

	// --------------------------------------------------------------
	// next state
	// --------------------------------------------------------------
	always_comb begin
		s_d           = s_q;
		s_d.mem.wr    = 1'b0;
		s_d.mem.rd    = 1'b0;
		s_d.mem.idx   = 1'b0;
		s_d.pc_load   = 1'b0;
		s_d.pop_valid = 1'b0;
		s_d.ptr_valid = 1'b0;
		case (s_q.state)
			daa_pkg::ST_IDLE: begin
				if (cmd_i.valid) begin
					case (cmd_i.op)
						daa_pkg::OP_IDX_SHORT: begin
							s_d.mem = idx_access(add16(s_q.base, sext7(cmd_i.disp7)),
									cmd_i.alu, cmd_i.value);
						end
						daa_pkg::OP_IDX_LONG: begin
							s_d.state      = daa_pkg::ST_LONG;
							s_d.pend_alu   = cmd_i.alu;
							s_d.pend_value = cmd_i.value;
						end
						daa_pkg::OP_PUSH, daa_pkg::OP_CALL, daa_pkg::OP_INTR: begin
							s_d.sp  = dec16(s_q.sp);
							s_d.mem = stack_access(dec16(s_q.sp), cmd_i.value, 1'b1);
						end
						daa_pkg::OP_POP, daa_pkg::OP_RET: begin
							s_d.mem     = stack_access(s_q.sp, 16'h0000, 1'b0);
							s_d.sp      = inc16(s_q.sp);
							s_d.pend_pc = (cmd_i.op == daa_pkg::OP_RET);
							s_d.state   = daa_pkg::ST_POPW;
						end
						daa_pkg::OP_WR_BASE: begin
							s_d.base = cmd_i.value;
						end
						daa_pkg::OP_BASE_FROM_SP: begin
							s_d.base = s_q.sp;
						end
						daa_pkg::OP_WR_STACK: begin
							s_d.sp = cmd_i.value;
						end
						daa_pkg::OP_MOD_STEP: begin
							s_d.ptr       = mod_ptr;
							s_d.ptr_valid = 1'b1;
						end
						default: begin
							s_d.state = daa_pkg::ST_IDLE;
						end
					endcase
				end
			end
			daa_pkg::ST_LONG: begin
				s_d.mem   = idx_access(add16(s_q.base, ext_word_i), s_q.pend_alu,
						s_q.pend_value);
				s_d.state = daa_pkg::ST_IDLE;
			end
			daa_pkg::ST_POPW: begin
				if (s_q.pend_pc) begin
					s_d.pc      = mem_rdata_i;
					s_d.pc_load = 1'b1;
				end else begin
					s_d.pop_data  = mem_rdata_i;
					s_d.pop_valid = 1'b1;
				end
				s_d.pend_pc = 1'b0;
				s_d.state   = daa_pkg::ST_IDLE;
			end
			default: begin
				s_d.state = daa_pkg::ST_IDLE;
			end
		endcase
		// busy is registered so the output comes straight from a flop
		s_d.busy = (s_d.state != daa_pkg::ST_IDLE);
	end

	// --------------------------------------------------------------
	// state register
	// --------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			s_q            <= '0;
			s_q.state      <= daa_pkg::ST_IDLE;
			s_q.base       <= daa_pkg::BASE_RESET;
			s_q.sp         <= daa_pkg::STACK_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// --------------------------------------------------------------
	// memory request and sequencing
	// --------------------------------------------------------------
	assign mem_o                   = s_q.mem;
	assign busy_o                  = s_q.busy;

	// --------------------------------------------------------------
	// pointers
	// --------------------------------------------------------------
	assign index_base_pointer_o    = s_q.base;
	assign stack_top_pointer_o     = s_q.sp;
	assign address_pointer_o       = s_q.ptr;
	assign address_pointer_valid_o = s_q.ptr_valid;

	// --------------------------------------------------------------
	// stack results
	// --------------------------------------------------------------
	assign program_counter_o       = s_q.pc;
	assign program_counter_load_o  = s_q.pc_load;
	assign pop_data_o              = s_q.pop_data;
	assign pop_valid_o             = s_q.pop_valid;

endmodule : data_address_arithmetic

// ===== dsp_data_mem_model.sv
// data memory model answering the address arithmetic block
`timescale 1ns/1ns
module dsp_data_mem_model (
	// clock
	input  wire logic          clk_sys_i,
	// access from the block
	input  wire daa_pkg::mem_t mem_i,
	// read data back
	output logic [15:0]        rdata_o
);
	logic [15:0] mem_q [0:255];
	logic [15:0] last_q = 16'h0000;
	assign rdata_o = mem_i.rd ? mem_q[mem_i.addr[7:0]] : ~last_q;
	always_ff @(posedge clk_sys_i) begin
		last_q <= rdata_o;
		if (mem_i.wr) begin
			mem_q[mem_i.addr[7:0]] <= mem_i.wdata;
		end
	end
endmodule : dsp_data_mem_model

// ===== daa_sva.sv
// checker: timing relations of data address arithmetic
`timescale 1ns/1ns
module daa_sva (
	// clock and reset
	input wire logic          clk_sys_i,
	input wire logic          rst_i,
	// observed ports
	input wire daa_pkg::cmd_t cmd_i,
	input wire logic [15:0]   ext_word_i,
	input wire logic [15:0]   mem_rdata_i,
	input wire daa_pkg::mem_t mem_o,
	input wire logic          busy_o,
	input wire logic [15:0]   index_base_pointer_o,
	input wire logic [15:0]   stack_top_pointer_o,
	input wire logic [15:0]   program_counter_o,
	input wire logic          program_counter_load_o,
	input wire logic [15:0]   pop_data_o,
	input wire logic          pop_valid_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	logic tk;
	assign tk = cmd_i.valid && !busy_o;
	AST_SHORT: assert property (tk && cmd_i.op == daa_pkg::OP_IDX_SHORT |=> mem_o.idx &&
		mem_o.addr == $past(index_base_pointer_o) + $past({{9{cmd_i.disp7[6]}}, cmd_i.disp7}))
		else $error("short indexed address wrong");
	AST_LONG: assert property (tk && cmd_i.op == daa_pkg::OP_IDX_LONG |=> busy_o ##1
		(mem_o.idx && mem_o.addr == $past(index_base_pointer_o, 2) + $past(ext_word_i)))
		else $error("long indexed access wrong");
	AST_BASE_KEPT: assert property (tk && cmd_i.op == daa_pkg::OP_IDX_SHORT |=>
		$stable(index_base_pointer_o)) else $error("base changed by access");
	AST_ALU: assert property (tk && cmd_i.op == daa_pkg::OP_IDX_SHORT |=> mem_o.alu ==
		$past(cmd_i.alu) && mem_o.wr == ($past(cmd_i.alu) == daa_pkg::ALU_STORE))
		else $error("indexed operation wrong");
	AST_BASE_SP: assert property (tk && cmd_i.op == daa_pkg::OP_BASE_FROM_SP |=>
		index_base_pointer_o == $past(stack_top_pointer_o)) else $error("base not loaded");
	AST_SP_WR: assert property (tk && cmd_i.op == daa_pkg::OP_WR_STACK |=>
		stack_top_pointer_o == $past(cmd_i.value)) else $error("stack pointer not written");
	AST_PUSH: assert property (tk && cmd_i.op inside {3, 5, 6} |=> mem_o.wr &&
		stack_top_pointer_o == $past(stack_top_pointer_o) - 16'h0001 &&
		mem_o.addr == stack_top_pointer_o && mem_o.wdata == $past(cmd_i.value))
		else $error("push wrong");
	AST_POP: assert property (tk && cmd_i.op == daa_pkg::OP_POP |=> (mem_o.rd &&
		mem_o.addr == $past(stack_top_pointer_o) && stack_top_pointer_o == mem_o.addr + 16'h0001)
		##1 (pop_valid_o && pop_data_o == $past(mem_rdata_i))) else $error("pop wrong");
	AST_RET: assert property (tk && cmd_i.op == daa_pkg::OP_RET |=> mem_o.rd ##1
		(program_counter_load_o && program_counter_o == $past(mem_rdata_i)))
		else $error("return wrong");
endmodule : daa_sva
bind data_address_arithmetic daa_sva chk_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
	.cmd_i(cmd_i), .ext_word_i(ext_word_i), .mem_rdata_i(mem_rdata_i), .mem_o(mem_o),
	.busy_o(busy_o), .index_base_pointer_o(index_base_pointer_o),
	.stack_top_pointer_o(stack_top_pointer_o), .program_counter_o(program_counter_o),
	.program_counter_load_o(program_counter_load_o), .pop_data_o(pop_data_o),
	.pop_valid_o(pop_valid_o));

// ===== testbench.sv
// testbench: indexed addressing, stack and modulo stepping
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
	$display("BAD %0t mismatch got %0h expected %0h", $time, (a), (b)); end end
module testbench;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	daa_pkg::cmd_t cmd = '0;
	logic [15:0] ext = 16'h0000;
	daa_pkg::mod_req_t mreq = '0;
	logic [15:0] rdata;
	daa_pkg::mem_t mem;
	logic busy, pcl, popv, apv;
	logic [15:0] base, sp, pc, popd, ap;
	int num_errors = 0;
	int cmp_count = 0;
	always #25 clk_sys_i = ~clk_sys_i;
	data_address_arithmetic dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cmd_i(cmd),
		.ext_word_i(ext), .mod_i(mreq), .mem_rdata_i(rdata), .mem_o(mem), .busy_o(busy),
		.index_base_pointer_o(base), .stack_top_pointer_o(sp), .program_counter_o(pc),
		.program_counter_load_o(pcl), .pop_data_o(popd), .pop_valid_o(popv),
		.address_pointer_o(ap), .address_pointer_valid_o(apv));
	dsp_data_mem_model mem_u (.clk_sys_i(clk_sys_i), .mem_i(mem), .rdata_o(rdata));
	task automatic issue(input daa_pkg::op_t op, input daa_pkg::alu_t alu,
		input logic [6:0] d7, input logic [15:0] v);
		@(posedge clk_sys_i) cmd <= '{1'b1, op, alu, d7, v};
		@(posedge clk_sys_i) cmd.valid <= 1'b0;
		#1;
	endtask : issue
	task automatic t_index;
		issue(daa_pkg::OP_WR_BASE, daa_pkg::ALU_ADD, 7'h00, 16'h0010);
		issue(daa_pkg::OP_IDX_SHORT, daa_pkg::ALU_XOR, 7'h40, 16'h0000);
		`CHK(mem.addr, 16'hFFD0)
		`CHK(({mem.idx, mem.rd, mem.alu}), ({2'b11, daa_pkg::ALU_XOR}))
		issue(daa_pkg::OP_IDX_SHORT, daa_pkg::ALU_STORE, 7'h3F, 16'h5A5A);
		`CHK(({mem.addr, mem.wr}), ({16'h004F, 1'b1}))
		`CHK(base, 16'h0010)
		@(posedge clk_sys_i) ext <= 16'hFFFF;
		issue(daa_pkg::OP_IDX_LONG, daa_pkg::ALU_SUB, 7'h00, 16'h0000);
		`CHK(({busy, mem.idx}), 2'b10)
		@(posedge clk_sys_i) #1;
		`CHK(({busy, mem.idx, mem.addr}), ({2'b01, 16'h000F}))
		`CHK(base, 16'h0010)
	endtask : t_index
	task automatic t_stack;
		issue(daa_pkg::OP_WR_STACK, daa_pkg::ALU_ADD, 7'h00, 16'h0100);
		`CHK(sp, 16'h0100)
		issue(daa_pkg::OP_PUSH, daa_pkg::ALU_ADD, 7'h00, 16'h1234);
		`CHK(({sp, mem.addr, mem.wr}), ({16'h00FF, 16'h00FF, 1'b1}))
		issue(daa_pkg::OP_CALL, daa_pkg::ALU_ADD, 7'h00, 16'hBEEF);
		`CHK(({sp, mem.wdata}), ({16'h00FE, 16'hBEEF}))
		issue(daa_pkg::OP_RET, daa_pkg::ALU_ADD, 7'h00, 16'h0000);
		@(posedge clk_sys_i) #1;
		`CHK(({pcl, pc, sp}), ({1'b1, 16'hBEEF, 16'h00FF}))
		issue(daa_pkg::OP_INTR, daa_pkg::ALU_ADD, 7'h00, 16'h0777);
		`CHK(({sp, mem.addr}), ({16'h00FE, 16'h00FE}))
		issue(daa_pkg::OP_RET, daa_pkg::ALU_ADD, 7'h00, 16'h0000);
		@(posedge clk_sys_i) #1;
		`CHK(({pcl, pc, sp}), ({1'b1, 16'h0777, 16'h00FF}))
		issue(daa_pkg::OP_POP, daa_pkg::ALU_ADD, 7'h00, 16'h0000);
		@(posedge clk_sys_i) #1;
		`CHK(({popv, popd, sp}), ({1'b1, 16'h1234, 16'h0100}))
		issue(daa_pkg::OP_BASE_FROM_SP, daa_pkg::ALU_ADD, 7'h00, 16'h0000);
		`CHK(base, 16'h0100)
	endtask : t_stack
	task automatic t_modulo;
		@(posedge clk_sys_i) mreq <= '{16'h0010, 16'hFFFD, 16'h0006};
		issue(daa_pkg::OP_MOD_STEP, daa_pkg::ALU_ADD, 7'h00, 16'h0000);
		`CHK(({apv, ap}), ({1'b1, 16'h0016}))
		@(posedge clk_sys_i) mreq <= '{16'h0016, 16'hFFFD, 16'h0006};
		issue(daa_pkg::OP_MOD_STEP, daa_pkg::ALU_ADD, 7'h00, 16'h0000);
		`CHK(ap, 16'h0013)
	endtask : t_modulo
	task automatic stop_test;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : stop_test
	initial begin
		repeat (10) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		t_index();
		t_stack();
		t_modulo();
		stop_test();
	end
	initial begin
		#100000;
		num_errors++;
		stop_test();
	end
endmodule : testbench
